// ===== include/sws_pkg.sv
// Purpose: Constants for the sleep and wakeup sequencer
// Assumes: 8-bit I/O register bus of the CPU, two I/O banks
// Notes:   Functional notes follow
//
// Functional notes
// - Firmware sleep bit halts CPU until wake
// - Any unmasked pending interrupt wakes, ignoring GIE
// - Sleep forces CPU clock to internal oscillator
// - Internal oscillator restarts at once on wake
// - Sleep leaves external oscillator running
// - Instruction after sleep runs before any ISR
// - Sleep bit asserts halt request immediately
// - Power-down asserts on falling edge after ack
// - Power-down stops flash, oscillator, filter, bandgap
// - Wake interrupt synchronised on 32 kHz fall
// - Next 32 kHz rise releases power-down
// - Next 32 kHz rise samples reset and LOW_VOLTAGE_DETECTOR
// - Next 32 kHz fall drops halt request
// - Wake to running within 75 to 105 us
// - Reset level codes 00, 01, reserved 10
// - Reset level 11 gives no reset, readable
// - Trip select codes 000 to 011, rest reserved
// - Low-voltage control only in second I/O bank
// - Detector duty-cycled during sleep
// - Duty field 00=128 01=512 10=32 11=8
// - Sleep request is bit 3 of status control

package sws_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [8:0] SYS_STATUS_CONTROL_ADDR = 9'h0ff;
   localparam logic [8:0] LOW_VOLTAGE_CONTROL_ADDR = 9'h1e3;
   localparam logic [8:0] VOLTAGE_COMPARE_ADDR = 9'h1e4;
   localparam logic [8:0] MONITOR_DUTY_ADDR = 9'h1eb;
   localparam int SLEEP_BIT = 3;
   localparam int STOP_BIT = 0;
   localparam int GIES_BIT = 7;
   localparam int LEVEL_LSB = 4;
   localparam int TRIP_LSB = 0;
   localparam int DUTY_LSB = 6;
   localparam logic [7:0] LVC_MASK = 8'h37;
   localparam logic [7:0] DUTY_MASK = 8'hc0;
   localparam logic [7:0] LVC_RESET = 8'h00;
   localparam logic [7:0] DUTY_RESET = 8'h00;
   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] LEVEL_2V6 = 2'h0;
   localparam logic [1:0] LEVEL_2V9 = 2'h1;
   localparam logic [1:0] LEVEL_OFF = 2'h3;
   localparam logic [2:0] TRIP_MAX = 3'h3;
   localparam logic [9:0] DUTY_128 = 10'h080;
   localparam logic [9:0] DUTY_512 = 10'h200;
   localparam logic [9:0] DUTY_32 = 10'h020;
   localparam logic [9:0] DUTY_8 = 10'h008;
   localparam int OSC_RECOVER_LP_CYCLES = 3;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int WAKE_MIN_US = 75;
   localparam int WAKE_MAX_US = 105;
   localparam int WAKE_MIN_CYC = WAKE_MIN_US * CLK_MHZ;
   localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;

   typedef enum logic [2:0] {
      SWS_AWAKE, SWS_WAIT_ACK, SWS_WAIT_FALL, SWS_ASLEEP,
      SWS_SYNCED, SWS_POWERED, SWS_SAMPLED
   } sws_state_t;
endpackage

// ===== src/sws_sync_edge.sv
// Purpose: Two-stage synchroniser with edge pulses
// Assumes: Input from another domain or a pin
// Notes:   Edge detect reads the second stage only
`timescale 1ns/1ps
module sws_sync_edge (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   input  wire logic i_async,
   output logic      o_level,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise  = sync_reg & ~prev_reg;
   assign o_fall  = ~sync_reg & prev_reg;
endmodule

// ===== src/sws_duty_timer.sv
// Purpose: Duty-cycle gate for the voltage monitor in sleep
// Assumes: One pulse per low-power clock period
// Notes:   Monitor alternates on and off for equal spans
`timescale 1ns/1ps
module sws_duty_timer (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_asleep,
   input  wire logic       i_lp_tick,
   input  wire logic [1:0] i_duty_sel,
   output logic            o_monitor_on
);
   logic [9:0] count_reg;
   logic       phase_reg;
   logic [9:0] span;

   function automatic logic [9:0] duty_span(input logic [1:0] sel);
      case (sel)
         2'h0:    duty_span = sws_pkg::DUTY_128;
         2'h1:    duty_span = sws_pkg::DUTY_512;
         2'h2:    duty_span = sws_pkg::DUTY_32;
         default: duty_span = sws_pkg::DUTY_8;
      endcase
   endfunction

   assign span = duty_span(i_duty_sel);

   // Awake the monitor runs full time
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_reg <= 10'h000;
         phase_reg <= 1'b1;
      end else if (!i_asleep) begin
         count_reg <= 10'h000;
         phase_reg <= 1'b1;
      end else if (i_lp_tick) begin
         if (count_reg + 10'h001 >= span) begin
            count_reg <= 10'h000;
            phase_reg <= ~phase_reg;
         end else begin
            count_reg <= count_reg + 10'h001;
         end
      end
   end

   assign o_monitor_on = phase_reg;
endmodule

// ===== src/sws_sleep_wake_sequencer.sv
// Purpose: Sleep entry and wake sequencing, voltage monitor settings
// Assumes: CPU clock and 32 kHz clock arrive as pins, sampled here
// Notes:   Register port is the CPU I/O bus, bank flag on address
`timescale 1ns/1ps
module sws_sleep_wake_sequencer (
   input  wire logic       i_ref_clk,
   input  wire logic       i_reset_n,
   input  wire logic       i_processor_clock,
   input  wire logic       i_lp_clk,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic       i_io_bank_select,
   input  wire logic [7:0] i_io_addr,
   input  wire logic [7:0] i_io_wdata,
   output logic [7:0]      o_io_rdata,
   input  wire logic       i_cpu_halt_ack,
   input  wire logic       i_irq_pending_unmasked,
   input  wire logic       i_global_int_enable,
   input  wire logic       i_precise_reset_cmp,
   input  wire logic       i_lvd_cmp,
   output logic            o_cpu_halt_request,
   output logic            o_global_power_down,
   output logic            o_force_internal_osc,
   output logic            o_stop_cpu,
   output logic            o_monitor_enable,
   output logic            o_precise_reset_detector,
   output logic [1:0]      o_precise_reset_level,
   output logic [2:0]      o_lvd_trip_select,
   output logic            o_low_voltage_detector,
   output logic            o_wake_too_slow
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic cpu_lvl, cpu_rise, cpu_fall;
   logic lp_lvl, lp_rise, lp_fall;
   logic ack_lvl, irq_lvl, precise_reset_detector_lvl, lvd_lvl, gie_lvl;
   // Interrupt enable lives in the CPU clock domain, so it is synced too
   logic [4:0] aux_meta_reg, aux_sync_reg;

   sws_sync_edge u_cpu_clk (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_async   (i_processor_clock),
      .o_level   (cpu_lvl),
      .o_rise    (cpu_rise),
      .o_fall    (cpu_fall)
   );

   sws_sync_edge u_lp_clk (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_async   (i_lp_clk),
      .o_level   (lp_lvl),
      .o_rise    (lp_rise),
      .o_fall    (lp_fall)
   );

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aux_meta_reg <= 5'h00;
         aux_sync_reg <= 5'h00;
      end else begin
         aux_meta_reg <= {i_global_int_enable, i_cpu_halt_ack,
                          i_irq_pending_unmasked,
                          i_precise_reset_cmp, i_lvd_cmp};
         aux_sync_reg <= aux_meta_reg;
      end
   end

   assign gie_lvl  = aux_sync_reg[4];
   assign ack_lvl  = aux_sync_reg[3];
   assign irq_lvl  = aux_sync_reg[2];
   assign precise_reset_detector_lvl = aux_sync_reg[1];
   assign lvd_lvl  = aux_sync_reg[0];

   // ---------------------------------------------------------------
   // Register port
   // ---------------------------------------------------------------
   logic [7:0] lvc_reg;
   logic [7:0] duty_reg;
   logic       sleep_reg;
   logic       stop_reg;
   logic       wr_scr, wr_lvc, wr_duty;
   logic       stop_next;

   // Status control sits in both banks; the rest needs bank 1
   assign wr_scr  = i_io_wr &&
                    i_io_addr == sws_pkg::SYS_STATUS_CONTROL_ADDR[7:0];
   assign wr_lvc  = i_io_wr && i_io_bank_select &&
                    i_io_addr == sws_pkg::LOW_VOLTAGE_CONTROL_ADDR[7:0];
   assign wr_duty = i_io_wr && i_io_bank_select &&
                    i_io_addr == sws_pkg::MONITOR_DUTY_ADDR[7:0];

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lvc_reg <= sws_pkg::LVC_RESET;
      end else if (wr_lvc) begin
         lvc_reg <= i_io_wdata & sws_pkg::LVC_MASK;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         duty_reg <= sws_pkg::DUTY_RESET;
      end else if (wr_duty) begin
         duty_reg <= i_io_wdata & sws_pkg::DUTY_MASK;
      end
   end

   // Stop halts the CPU until reset or a status control write with bit 0 clear; firmware keeps it clear to wake
   assign stop_next = wr_scr ? i_io_wdata[sws_pkg::STOP_BIT] : stop_reg;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stop_reg <= 1'b0;
      end else begin
         stop_reg <= stop_next;
      end
   end

   always_comb begin
      o_io_rdata = 8'h00;
      if (i_io_rd && i_io_addr == sws_pkg::SYS_STATUS_CONTROL_ADDR[7:0]) begin
         o_io_rdata[sws_pkg::GIES_BIT]  = gie_lvl;
         o_io_rdata[sws_pkg::SLEEP_BIT] = sleep_reg;
         o_io_rdata[sws_pkg::STOP_BIT]  = stop_reg;
      end else if (i_io_rd && i_io_bank_select &&
                   i_io_addr == sws_pkg::LOW_VOLTAGE_CONTROL_ADDR[7:0]) begin
         o_io_rdata = lvc_reg;
      end else if (i_io_rd && i_io_bank_select &&
                   i_io_addr == sws_pkg::VOLTAGE_COMPARE_ADDR[7:0]) begin
         o_io_rdata = {6'h00, o_low_voltage_detector,
                       o_precise_reset_detector};
      end else if (i_io_rd && i_io_bank_select &&
                   i_io_addr == sws_pkg::MONITOR_DUTY_ADDR[7:0]) begin
         o_io_rdata = duty_reg;
      end
   end

   assign o_precise_reset_level =
      lvc_reg[sws_pkg::LEVEL_LSB +: 2];
   assign o_lvd_trip_select = lvc_reg[sws_pkg::TRIP_LSB +: 3];
   assign o_stop_cpu = stop_reg;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   sws_pkg::sws_state_t state_reg;
   logic                halt_reg;
   logic                pd_reg;
   logic                sleep_set;

   // Halt request goes out combinationally with the write
   assign sleep_set = wr_scr && i_io_wdata[sws_pkg::SLEEP_BIT]
                      && state_reg == sws_pkg::SWS_AWAKE;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= sws_pkg::SWS_AWAKE;
      end else begin
         case (state_reg)
            sws_pkg::SWS_AWAKE: begin
               if (sleep_set) begin
                  state_reg <= sws_pkg::SWS_WAIT_ACK;
               end
            end
            sws_pkg::SWS_WAIT_ACK: begin
               if (ack_lvl) begin
                  state_reg <= sws_pkg::SWS_WAIT_FALL;
               end
            end
            sws_pkg::SWS_WAIT_FALL: begin
               if (cpu_fall) begin
                  state_reg <= sws_pkg::SWS_ASLEEP;
               end
            end
            sws_pkg::SWS_ASLEEP: begin
               // Any unmasked pending source, GIE not consulted
               if (irq_lvl && lp_fall) begin
                  state_reg <= sws_pkg::SWS_SYNCED;
               end
            end
            sws_pkg::SWS_SYNCED: begin
               if (lp_rise) begin
                  state_reg <= sws_pkg::SWS_POWERED;
               end
            end
            sws_pkg::SWS_POWERED: begin
               if (lp_rise) begin
                  state_reg <= sws_pkg::SWS_SAMPLED;
               end
            end
            sws_pkg::SWS_SAMPLED: begin
               if (lp_fall) begin
                  state_reg <= sws_pkg::SWS_AWAKE;
               end
            end
            default: state_reg <= sws_pkg::SWS_AWAKE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sleep_reg <= 1'b0;
      end else if (sleep_set) begin
         sleep_reg <= 1'b1;
      end else if (state_reg == sws_pkg::SWS_SAMPLED && lp_fall) begin
         sleep_reg <= 1'b0;
      end
   end

   // Halt ends by itself; CPU resumes at next instruction, ISR after
   assign halt_reg = state_reg != sws_pkg::SWS_AWAKE;
   assign o_cpu_halt_request = halt_reg | sleep_set;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pd_reg <= 1'b0;
      end else if (state_reg == sws_pkg::SWS_WAIT_FALL && cpu_fall) begin
         pd_reg <= 1'b1;
      end else if (state_reg == sws_pkg::SWS_SYNCED && lp_rise) begin
         pd_reg <= 1'b0;
      end
   end

   assign o_global_power_down = pd_reg;

   // Clock select held on internal from sleep entry; external not touched
   assign o_force_internal_osc = halt_reg;

   // ---------------------------------------------------------------
   // Comparator sampling
   // ---------------------------------------------------------------
   logic precise_reset_detector_reg, lvd_reg;

   // Frozen while powered down; sampled again on the settle edge
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         precise_reset_detector_reg <= 1'b0;
         lvd_reg  <= 1'b0;
      end else if (!pd_reg && (state_reg != sws_pkg::SWS_POWERED
                               || lp_rise)) begin
         precise_reset_detector_reg <= precise_reset_detector_lvl;
         lvd_reg  <= lvd_lvl;
      end
   end

   assign o_precise_reset_detector = precise_reset_detector_reg;
   assign o_low_voltage_detector   = lvd_reg;

   sws_duty_timer u_duty (
      .i_ref_clk    (i_ref_clk),
      .i_reset_n    (i_reset_n),
      .i_asleep     (pd_reg),
      .i_lp_tick    (lp_rise),
      .i_duty_sel   (duty_reg[sws_pkg::DUTY_LSB +: 2]),
      .o_monitor_on (o_monitor_enable)
   );

   // ---------------------------------------------------------------
   // Wake latency watch
   // ---------------------------------------------------------------
   logic [12:0] wake_cnt_reg;
   logic        slow_reg;

   // Flags a wake that overran the longest time
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wake_cnt_reg <= 13'h0000;
         slow_reg     <= 1'b0;
      end else if (state_reg == sws_pkg::SWS_ASLEEP) begin
         wake_cnt_reg <= 13'h0000;
      end else if (halt_reg && !pd_reg && sleep_reg) begin
         wake_cnt_reg <= wake_cnt_reg + 13'h0001;
         if (wake_cnt_reg >= 13'(sws_pkg::WAKE_MAX_CYC)) begin
            slow_reg <= 1'b1;
         end
      end
   end

   assign o_wake_too_slow = slow_reg;

   logic unused_ok;
   assign unused_ok = cpu_lvl ^ cpu_rise ^ lp_lvl;
endmodule

// ===== verif/sws_cpu_model.sv
// Purpose: CPU core and interrupt logic beside the sequencer
// Assumes: CPU clock from internal oscillator, 4 MHz
// Notes:   Pending interrupt clears once the CPU resumes
`timescale 1ns/1ps
module sws_cpu_model (
   input  wire logic i_halt_request,
   input  wire logic i_power_down,
   input  wire logic i_irq_raise,
   input  wire logic i_irq_enable,
   output logic      o_cpu_clk,
   output logic      o_halt_ack,
   output logic      o_irq_unmasked
);
   logic pend = 1'b0;
   initial o_cpu_clk = 1'b0;
   initial o_halt_ack = 1'b0;
   // Oscillator dead in power-down, so no late edges
   always #125 if (!i_power_down) o_cpu_clk = ~o_cpu_clk;
   always @(posedge o_cpu_clk) o_halt_ack <= i_halt_request;
   always @(posedge i_irq_raise) pend = 1'b1;
   always @(negedge o_halt_ack) pend = 1'b0;
   assign o_irq_unmasked = pend & i_irq_enable;
endmodule

// ===== verif/sws_sleep_wake_sequencer_assertions.sv
// Purpose: Port checks for the sleep and wakeup sequencer
// Assumes: 32 kHz low-power clock at a 40 MHz reference
// Notes:   Wake timing figure tied to that clock ratio
`timescale 1ns/1ps
module sws_sleep_wake_sequencer_assertions (
   input wire logic       i_ref_clk,
   input wire logic       i_reset_n,
   input wire logic       i_io_wr,
   input wire logic       i_io_bank_select,
   input wire logic [7:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   input wire logic       i_cpu_halt_ack,
   input wire logic       i_irq_pending_unmasked,
   input wire logic       o_cpu_halt_request,
   input wire logic       o_global_power_down,
   input wire logic       o_force_internal_osc,
   input wire logic [1:0] o_precise_reset_level,
   input wire logic [2:0] o_lvd_trip_select
);
   localparam int LP_HALF = 625;
   logic [15:0] wake_cnt;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // Cycles since power-down let go; wraps harmlessly while awake
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wake_cnt <= 16'h0000;
      end else begin
         wake_cnt <= o_global_power_down ? 16'h0000 : wake_cnt + 16'h0001;
      end
   end
   a_halt_on_write: assert property (i_io_wr && !i_io_bank_select &&
      i_io_addr == 8'hff && i_io_wdata[3] |-> o_cpu_halt_request)
      else $error("halt request missing on sleep write");
   a_reset_awake: assert property ($rose(i_reset_n) |->
      !o_cpu_halt_request && !o_global_power_down)
      else $error("not awake after reset");
   a_pd_after_ack: assert property ($rose(o_global_power_down) |->
      i_cpu_halt_ack && o_cpu_halt_request)
      else $error("power-down without acknowledge");
   a_pd_keeps_halt: assert property (o_global_power_down |->
      o_cpu_halt_request) else $error("CPU released in power-down");
   a_pd_forces_osc: assert property (o_global_power_down |->
      o_force_internal_osc) else $error("clock not forced internal");
   a_wake_needs_irq: assert property ($fell(o_global_power_down) |->
      $past(i_irq_pending_unmasked, 4)) else $error("wake without irq");
   a_halt_drop_time: assert property ($fell(o_cpu_halt_request) |->
      wake_cnt >= 3 * LP_HALF - 5 && wake_cnt <= 3 * LP_HALF + 5)
      else $error("halt request dropped at wrong time");
   a_trip_write: assert property (i_io_wr && i_io_bank_select &&
      i_io_addr == 8'he3 && !i_io_wdata[2] |=>
      o_precise_reset_level == $past(i_io_wdata[5:4]) &&
      o_lvd_trip_select == $past(i_io_wdata[2:0]))
      else $error("voltage fields not written");
   a_bank_guard: assert property (i_io_wr && !i_io_bank_select &&
      i_io_addr == 8'he3 |=> $stable(o_lvd_trip_select))
      else $error("bank zero write reached voltage control");
   c_sleep: cover property ($rose(o_global_power_down));
   c_wake: cover property ($fell(o_cpu_halt_request));
   c_lvc: cover property (i_io_wr && i_io_bank_select && i_io_addr == 8'he3);
endmodule
bind sws_sleep_wake_sequencer sws_sleep_wake_sequencer_assertions u_chk (
   .i_ref_clk, .i_reset_n, .i_io_wr, .i_io_bank_select, .i_io_addr,
   .i_io_wdata, .i_cpu_halt_ack, .i_irq_pending_unmasked,
   .o_cpu_halt_request, .o_global_power_down, .o_force_internal_osc,
   .o_precise_reset_level, .o_lvd_trip_select);

// ===== verif/sws_sleep_wake_sequencer_tb_top.sv
// Purpose: Self-checking bench for the sleep and wakeup sequencer
// Assumes: 40 MHz reference, free-running 32 kHz clock
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module sws_sleep_wake_sequencer_tb_top;
   logic       i_ref_clk = 1'b0;
   logic       i_reset_n = 1'b0;
   logic       i_lp_clk = 1'b0;
   logic       i_io_wr = 1'b0;
   logic       i_io_rd = 1'b0;
   logic       i_io_bank_select = 1'b0;
   logic       i_global_int_enable = 1'b0;
   logic       i_precise_reset_cmp = 1'b0;
   logic       i_lvd_cmp = 1'b0;
   logic       irq_raise = 1'b0;
   logic       irq_enable = 1'b0;
   logic [7:0] i_io_addr = 8'h00;
   logic [7:0] i_io_wdata = 8'h00;
   logic [7:0] o_io_rdata;
   logic       i_processor_clock, i_cpu_halt_ack, i_irq_pending_unmasked;
   logic       o_cpu_halt_request, o_global_power_down, o_force_internal_osc;
   logic       o_stop_cpu, o_monitor_enable, o_precise_reset_detector;
   logic       o_low_voltage_detector, o_wake_too_slow;
   logic [1:0] o_precise_reset_level;
   logic [2:0] o_lvd_trip_select;
   int         errors = 0;
   int         cmp_count = 0;
   int         cycles = 0;
   always #12.5 i_ref_clk = ~i_ref_clk;
   always #15625 i_lp_clk = ~i_lp_clk;
   sws_sleep_wake_sequencer uut (.i_ref_clk, .i_reset_n, .i_processor_clock,
      .i_lp_clk, .i_io_wr, .i_io_rd, .i_io_bank_select, .i_io_addr,
      .i_io_wdata, .o_io_rdata, .i_cpu_halt_ack, .i_irq_pending_unmasked,
      .i_global_int_enable, .i_precise_reset_cmp, .i_lvd_cmp,
      .o_cpu_halt_request, .o_global_power_down, .o_force_internal_osc,
      .o_stop_cpu, .o_monitor_enable, .o_precise_reset_detector,
      .o_precise_reset_level, .o_lvd_trip_select, .o_low_voltage_detector,
      .o_wake_too_slow);
   sws_cpu_model cpu (.i_halt_request(o_cpu_halt_request),
      .i_power_down(o_global_power_down), .i_irq_raise(irq_raise),
      .i_irq_enable(irq_enable), .o_cpu_clk(i_processor_clock),
      .o_halt_ack(i_cpu_halt_ack), .o_irq_unmasked(i_irq_pending_unmasked));
   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task chk(input string name, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", name, e, g);
      end
   endtask
   task bchk(input string name, input logic e, input logic g);
      chk(name, {7'h00, e}, {7'h00, g});
   endtask
   task wr_reg(input logic b, input logic [7:0] a, input logic [7:0] d);
      i_io_bank_select = b;
      i_io_addr = a;
      i_io_wdata = d;
      i_io_wr = 1'b1;
      step(1);
      i_io_wr = 1'b0;
      step(1);
   endtask
   task rd_chk(input logic b, input logic [7:0] a, m, e);
      i_io_bank_select = b;
      i_io_addr = a;
      i_io_rd = 1'b1;
      #5;
      chk("rdata", e, o_io_rdata & m);
      step(1);
      i_io_rd = 1'b0;
      step(1);
   endtask
   task wait_pd;
      int n;
      n = 0;
      while (o_global_power_down !== 1'b1 && n < 400) begin
         step(1);
         n++;
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_reset;
      bchk("halt", 1'b0, o_cpu_halt_request);
      bchk("pd", 1'b0, o_global_power_down);
      bchk("monitor", 1'b1, o_monitor_enable);
      rd_chk(1'b1, 8'he3, 8'hff, 8'h00);
      rd_chk(1'b0, 8'hff, 8'h09, 8'h00);
   endtask
   task t_regs;
      for (int i = 0; i < 4; i++) begin
         if (i != 2) begin
            wr_reg(1'b1, 8'he3, 8'hc8 | 8'(i << 4) | 8'(i));
            rd_chk(1'b1, 8'he3, 8'hff, 8'(i << 4) | 8'(i));
            chk("level", 8'(i), {6'h00, o_precise_reset_level});
            chk("trip", 8'(i), {5'h00, o_lvd_trip_select});
         end
      end
      wr_reg(1'b0, 8'he3, 8'h00);
      rd_chk(1'b1, 8'he3, 8'hff, 8'h33);
      rd_chk(1'b0, 8'he3, 8'hff, 8'h00);
      wr_reg(1'b1, 8'heb, 8'hff);
      rd_chk(1'b1, 8'heb, 8'hff, 8'hc0);
      rd_chk(1'b0, 8'h10, 8'hff, 8'h00);
      wr_reg(1'b0, 8'hff, 8'h01);
      bchk("stop_set", 1'b1, o_stop_cpu);
      bchk("halt_stop", 1'b0, o_cpu_halt_request);
      rd_chk(1'b0, 8'hff, 8'h09, 8'h01);
      wr_reg(1'b0, 8'hff, 8'h00);
   endtask
   task t_sleep(input logic g, input int hold);
      int n;
      int offs;
      offs = 0;
      i_global_int_enable = g;
      i_io_bank_select = 1'b0;
      i_io_addr = 8'hff;
      i_io_wdata = 8'h08;
      i_io_wr = 1'b1;
      #1;
      bchk("halt_now", 1'b1, o_cpu_halt_request);
      step(1);
      i_io_wr = 1'b0;
      wait_pd();
      bchk("pd", 1'b1, o_global_power_down);
      bchk("osc", 1'b1, o_force_internal_osc);
      // Comparators move while powered down; only the wake edge samples
      i_precise_reset_cmp = ~i_precise_reset_cmp;
      i_lvd_cmp = i_precise_reset_cmp;
      step(5);
      bchk("precise_reset_detector_hold", ~i_precise_reset_cmp, o_precise_reset_detector);
      irq_raise = 1'b1;
      // One tick per sample: span 8 gives exactly 8 off samples in 18
      repeat (hold) begin
         step(1250);
         if (o_monitor_enable !== 1'b1) offs++;
      end
      if (hold > 0) chk("duty_off", 8'h08, 8'(offs));
      bchk("pd_masked", 1'b1, o_global_power_down);
      irq_enable = 1'b1;
      n = 0;
      while (o_cpu_halt_request !== 1'b0 && n < 6000) begin
         step(1);
         n++;
      end
      bchk("wake", 1'b1, n <= sws_pkg::WAKE_MAX_CYC);
      bchk("slow", 1'b0, o_wake_too_slow);
      bchk("pd_off", 1'b0, o_global_power_down);
      bchk("monitor_wake", 1'b1, o_monitor_enable);
      bchk("stop", 1'b0, o_stop_cpu);
      bchk("precise_reset_detector", i_precise_reset_cmp, o_precise_reset_detector);
      bchk("lvd", i_lvd_cmp, o_low_voltage_detector);
      step(20);
      irq_raise = 1'b0;
      irq_enable = 1'b0;
      rd_chk(1'b0, 8'hff, 8'h88, {g, 7'h00});
      rd_chk(1'b1, 8'he4, 8'hff, {6'h00, i_lvd_cmp, i_precise_reset_cmp});
   endtask
   task t_midreset;
      wr_reg(1'b0, 8'hff, 8'h08);
      wait_pd();
      i_reset_n = 1'b0;
      step(3);
      i_reset_n = 1'b1;
      step(2);
      bchk("halt_rst", 1'b0, o_cpu_halt_request);
      bchk("pd_rst", 1'b0, o_global_power_down);
      rd_chk(1'b1, 8'he3, 8'hff, 8'h00);
   endtask
   task end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Ceiling well above the roughly 30k cycles the scenarios need
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      step(10);
      i_reset_n = 1'b1;
      step(1);
      t_reset();
      t_regs();
      t_sleep(1'b0, 18);
      t_sleep(1'b1, 0);
      t_midreset();
      end_sim();
   end
endmodule
